/* rtl/panel_pkg.sv */
// Shared constants and types for the front-panel key and status logic
package panel_pkg;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int DEBOUNCE_US = 10000;
    localparam int COMBO_HOLD_US = 500000;
    localparam int BLINK_US = 250000;
    localparam int DONE_US = 1000000;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
    localparam int COMBO_HOLD_CYCLES = COMBO_HOLD_US * CLK_MHZ;
    localparam int BLINK_CYCLES = BLINK_US * CLK_MHZ;
    localparam int DONE_CYCLES = DONE_US * CLK_MHZ;

    // -------------------------------------------------------------------
    // Display value layout
    // -------------------------------------------------------------------
    localparam int DIGITS = 5;
    localparam int DIGIT_W = 4;
    localparam int VALUE_W = DIGITS * DIGIT_W;
    localparam int SEL_W = 3;
    localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
    localparam logic [DIGIT_W-1:0] BCD_MAX = 4'h9;
    localparam int IND_W = 14;

    // Indicator segment positions, segment N at bit N-1
    localparam int IND_CTRL_POWER = 0;
    localparam int IND_READY = 1;
    localparam int IND_ENABLED = 2;
    localparam int IND_MATCH = 3;
    localparam int IND_MAIN_POWER = 4;
    localparam int IND_CMD_A = 5;
    localparam int IND_CMD_B = 6;
    localparam int IND_ROTATION = 7;
    localparam int IND_POS_MODE = 8;
    localparam int IND_SPD_MODE = 9;
    localparam int IND_TRQ_MODE = 10;
    localparam int IND_JOG = 11;
    localparam int IND_FULL_LOOP = 12;
    localparam int IND_AUX_5V = 13;

    typedef enum logic [3:0] {
        FN_STATUS = 4'h1,
        FN_AUX = 4'h2,
        FN_PARAM = 4'h4,
        FN_MONITOR = 4'h8
    } panel_fn_e;

    typedef enum logic [1:0] {
        CTRL_POSITION = 2'h0,
        CTRL_SPEED = 2'h1,
        CTRL_TORQUE = 2'h2
    } ctrl_mode_e;

    typedef enum logic [2:0] {
        SHOW_READY = 3'h0,
        SHOW_RUN = 3'h1,
        SHOW_FWD_INHIBIT = 3'h2,
        SHOW_REV_INHIBIT = 3'h3,
        SHOW_NOT_READY = 3'h4,
        SHOW_ALARM = 3'h5,
        SHOW_FUNCTION = 3'h6,
        SHOW_DONE = 3'h7
    } show_code_e;

    typedef struct packed {
        logic control_power_on;
        logic servo_ready;
        logic servo_enabled;
        logic fault_present;
        logic bus_voltage_ok;
        logic alarm_active;
        logic [7:0] alarm_number;
        logic forward_overtravel_input;
        logic reverse_overtravel_input;
        ctrl_mode_e control_mode;
        logic speed_match_flag;
        logic position_done_flag;
        logic main_power_on;
        logic torque_cmd_over;
        logic speed_cmd_over;
        logic clear_input;
        logic pulse_input_active;
        logic rotation_detect_flag;
        logic jog_mode;
        logic program_jog_mode;
        logic full_closed_loop;
        logic aux_connector_5v_on;
    } drive_status_s;

    typedef struct packed {
        show_code_e code;
        panel_fn_e menu_fn;
        logic [VALUE_W-1:0] digits;
        logic [DIGITS-1:0] blink_mask;
        logic lit_phase;
    } display_s;

endpackage

/* rtl/key_debounce.sv */
// Pushbutton synchroniser and debouncer with press and release pulses
`timescale 1ns/1ps
module key_debounce #(
    parameter int STABLE_CYCLES = 2500000
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic key_pin,
    output logic held,
    output logic pressed,
    output logic released
);

    logic sync_a;
    logic sync_b;
    logic [31:0] stable_count;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= key_pin;
            sync_b <= sync_a;
        end
    end

    // Level is accepted only after it stays put for the whole window
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            held <= 1'b0;
            pressed <= 1'b0;
            released <= 1'b0;
            stable_count <= 32'h0;
        end else begin
            pressed <= 1'b0;
            released <= 1'b0;
            if (sync_b == held) begin
                stable_count <= 32'h0;
            end else if (stable_count >= 32'(STABLE_CYCLES - 1)) begin
                stable_count <= 32'h0;
                held <= sync_b;
                pressed <= sync_b;
                released <= ~sync_b;
            end else begin
                stable_count <= stable_count + 32'h1;
            end
        end
    end

endmodule

/* rtl/tick_timer.sv */
// Free-running phase toggle used for blinking and flashing
`timescale 1ns/1ps
module tick_timer #(
    parameter int HALF_CYCLES = 62500000
) (
    input wire logic ref_clk,
    input wire logic reset,
    output logic phase
);

    logic [31:0] count;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count <= 32'h0;
            phase <= 1'b1;
        end else if (count >= 32'(HALF_CYCLES - 1)) begin
            count <= 32'h0;
            phase <= ~phase;
        end else begin
            count <= count + 32'h1;
        end
    end

endmodule

/* rtl/panel_keys_status_display.sv */
// Front-panel key handling, function switching, status codes and indicator segments
// Notes on behaviour
// RULE1: Mode key advances the function; during an edit it commits the value.
// RULE2: Each up press raises the edited value at the selected digit.
// RULE3: Each down press lowers the edited value at the selected digit.
// RULE4: Shift key shows the stored value; in edit it moves digit left, digit blinks.
// RULE5: Holding up and down together clears an active alarm.
// RULE6: Mode presses cycle status, auxiliary, parameter and monitor functions.
// RULE7: Show ready code when ready and disabled, run code when enabled.
// RULE8: Open forward overtravel input shows the forward-inhibited code.
// RULE9: Open reverse overtravel input shows the reverse-inhibited code.
// RULE10: Fault or missing bus voltage shows not-ready; alarm flashes its number.
// RULE11: Segment 1 follows control power.
// RULE12: Segment 2 lit when the drive can accept servo-on.
// RULE13: Segment 3 follows servo enable.
// RULE14: Speed mode: segment 4 shows speed match within limit.
// RULE15: Position mode: segment 4 shows position error within limit.
// RULE16: Segment 5 follows main circuit power.
// RULE17: Segment 6 torque command over, segment 7 speed command over. Logic shows 6 only in torque mode, 7 only in speed mode.
// RULE18: Position mode: segment 6 clear input, segment 7 pulses arriving.
// RULE19: Segment 8 lit while motor speed exceeds rotation threshold.
// RULE20: Exactly one of segments 9, 10, 11 shows the control mode.
// RULE21: Segment 12 lit in either jog mode.
// RULE22: Segment 13 full closed loop, segment 14 auxiliary 5 V supplied.
// RULE23: Keys are debounced; up plus down hold is a distinct combination.
`timescale 1ns/1ps
module panel_keys_status_display
    import panel_pkg::*;
#(
    parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES,
    parameter int COMBO_HOLD_LEN = COMBO_HOLD_CYCLES,
    parameter int BLINK_LEN = BLINK_CYCLES,
    parameter int DONE_LEN = DONE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic key_mode,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_shift,
    input wire drive_status_s drive_status,
    input wire logic [VALUE_W-1:0] stored_value,
    output display_s display,
    output logic [IND_W-1:0] indicators,
    output logic value_commit,
    output logic [VALUE_W-1:0] commit_value,
    output logic alarm_reset
);

    // -------------------------------------------------------------------
    // Key conditioning
    // -------------------------------------------------------------------
    logic mode_held;
    logic mode_press;
    logic up_held;
    logic up_release;
    logic down_held;
    logic down_release;
    logic shift_held;
    logic shift_press;
    logic blink_phase;

    key_debounce #(.STABLE_CYCLES(DEBOUNCE_LEN)) u_mode_key (
        .ref_clk(ref_clk),
        .reset(reset),
        .key_pin(key_mode),
        .held(mode_held),
        .pressed(mode_press),
        .released()
    );

    key_debounce #(.STABLE_CYCLES(DEBOUNCE_LEN)) u_up_key (
        .ref_clk(ref_clk),
        .reset(reset),
        .key_pin(key_up),
        .held(up_held),
        .pressed(),
        .released(up_release)
    );

    key_debounce #(.STABLE_CYCLES(DEBOUNCE_LEN)) u_down_key (
        .ref_clk(ref_clk),
        .reset(reset),
        .key_pin(key_down),
        .held(down_held),
        .pressed(),
        .released(down_release)
    );

    key_debounce #(.STABLE_CYCLES(DEBOUNCE_LEN)) u_shift_key (
        .ref_clk(ref_clk),
        .reset(reset),
        .key_pin(key_shift),
        .held(shift_held),
        .pressed(shift_press),
        .released()
    );

    tick_timer #(.HALF_CYCLES(BLINK_LEN)) u_blink (
        .ref_clk(ref_clk),
        .reset(reset),
        .phase(blink_phase)
    );

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    // Decimal step with carry or borrow into higher digits, wrapping at the top
    function automatic logic [VALUE_W-1:0] bcd_step(input logic [VALUE_W-1:0] value,
                                                     input logic [SEL_W-1:0] sel,
                                                     input logic up);
        logic [VALUE_W-1:0] result;
        logic [DIGIT_W-1:0] d;
        logic carry;
        result = value;
        carry = 1'b1;
        for (int i = 0; i < DIGITS; i++) begin
            d = value[i*DIGIT_W +: DIGIT_W];
            if (i >= int'(sel) && carry) begin
                if (up) begin
                    carry = (d == BCD_MAX);
                    d = carry ? 4'h0 : d + 4'h1;
                end else begin
                    carry = (d == 4'h0);
                    d = carry ? BCD_MAX : d - 4'h1;
                end
            end
            result[i*DIGIT_W +: DIGIT_W] = d;
        end
        return result;
    endfunction

    function automatic panel_fn_e next_function(input panel_fn_e current);
        case (current)
            FN_STATUS: return FN_AUX;
            FN_AUX: return FN_PARAM;
            FN_PARAM: return FN_MONITOR;
            FN_MONITOR: return FN_STATUS;
            default: return FN_STATUS;
        endcase
    endfunction

    // -------------------------------------------------------------------
    // Up/down combination
    // -------------------------------------------------------------------
    logic combo_seen;
    logic combo_fired;
    logic [31:0] combo_count;
    logic up_edit;
    logic down_edit;

    // A release counts as an edit only if the other key never joined in
    assign up_edit = up_release && !combo_seen && !down_held;
    assign down_edit = down_release && !combo_seen && !up_held;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            combo_seen <= 1'b0;
        end else if (up_held && down_held) begin
            combo_seen <= 1'b1; // [RULE23]
        end else if (!up_held && !down_held) begin
            combo_seen <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            combo_count <= 32'h0;
            combo_fired <= 1'b0;
            alarm_reset <= 1'b0;
        end else begin
            alarm_reset <= 1'b0;
            if (!(up_held && down_held)) begin
                combo_count <= 32'h0;
                combo_fired <= 1'b0;
            end else if (combo_fired) begin
                combo_count <= 32'h0;
            end else if (combo_count >= 32'(COMBO_HOLD_LEN - 1)) begin
                combo_fired <= 1'b1;
                alarm_reset <= drive_status.alarm_active; // [RULE5]
            end else begin
                combo_count <= combo_count + 32'h1;
            end
        end
    end

    // -------------------------------------------------------------------
    // Function selection and value editing
    // -------------------------------------------------------------------
    panel_fn_e function_sel;
    logic editing;
    logic [VALUE_W-1:0] edit_value;
    logic [SEL_W-1:0] digit_sel;
    logic [31:0] done_count;
    logic done_showing;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            function_sel <= FN_STATUS;
        end else if (mode_press && !editing && !done_showing) begin
            function_sel <= next_function(function_sel); // [RULE1] [RULE6]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            editing <= 1'b0;
            edit_value <= '0;
            digit_sel <= SEL_RESET;
            value_commit <= 1'b0;
            commit_value <= '0;
        end else begin
            value_commit <= 1'b0;
            if (!editing) begin
                if (shift_press && function_sel != FN_STATUS) begin
                    editing <= 1'b1;
                    edit_value <= stored_value; // [RULE4]
                    digit_sel <= SEL_RESET;
                end
            end else if (mode_press) begin
                editing <= 1'b0;
                value_commit <= 1'b1; // [RULE1]
                commit_value <= edit_value;
            end else if (shift_press) begin
                if (digit_sel == SEL_W'(DIGITS - 1)) begin
                    digit_sel <= SEL_RESET;
                end else begin
                    digit_sel <= digit_sel + 3'h1; // [RULE4]
                end
            end else if (up_edit) begin
                edit_value <= bcd_step(edit_value, digit_sel, 1'b1); // [RULE2]
            end else if (down_edit) begin
                edit_value <= bcd_step(edit_value, digit_sel, 1'b0); // [RULE3]
            end
        end
    end

    // Commit acknowledgement stays on screen for a while, mode key meanwhile ignored
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            done_showing <= 1'b0;
            done_count <= 32'h0;
        end else if (value_commit) begin
            done_showing <= 1'b1;
            done_count <= 32'h0;
        end else if (done_showing) begin
            if (done_count >= 32'(DONE_LEN - 1)) begin
                done_showing <= 1'b0;
            end else begin
                done_count <= done_count + 32'h1;
            end
        end
    end

    // -------------------------------------------------------------------
    // Status code
    // -------------------------------------------------------------------
    show_code_e status_code;

    always_comb begin
        if (drive_status.alarm_active) begin
            status_code = SHOW_ALARM; // [RULE10]
        end else if (drive_status.fault_present || !drive_status.bus_voltage_ok) begin
            status_code = SHOW_NOT_READY; // [RULE10]
        end else if (!drive_status.forward_overtravel_input) begin
            status_code = SHOW_FWD_INHIBIT; // [RULE8]
        end else if (!drive_status.reverse_overtravel_input) begin
            status_code = SHOW_REV_INHIBIT; // [RULE9]
        end else if (drive_status.servo_enabled) begin
            status_code = SHOW_RUN; // [RULE7]
        end else begin
            status_code = SHOW_READY; // [RULE7]
        end
    end

    // -------------------------------------------------------------------
    // Display register
    // -------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            display.code <= SHOW_READY;
            display.menu_fn <= FN_STATUS;
            display.digits <= '0;
            display.blink_mask <= '0;
            display.lit_phase <= 1'b1;
        end else begin
            display.menu_fn <= function_sel;
            display.lit_phase <= blink_phase;
            display.blink_mask <= '0;
            display.digits <= '0;
            if (done_showing) begin
                display.code <= SHOW_DONE;
                display.blink_mask <= '1;
                display.digits <= commit_value;
            end else if (editing) begin
                display.code <= SHOW_FUNCTION;
                display.digits <= edit_value;
                display.blink_mask <= DIGITS'(1) << digit_sel; // [RULE4]
            end else if (function_sel == FN_STATUS) begin
                display.code <= status_code;
                if (status_code == SHOW_ALARM) begin
                    display.digits <= VALUE_W'(drive_status.alarm_number);
                    display.blink_mask <= '1; // [RULE10]
                end
            end else begin
                display.code <= SHOW_FUNCTION;
            end
        end
    end

    // -------------------------------------------------------------------
    // Indicator segments
    // -------------------------------------------------------------------
    logic pos_mode;
    logic spd_mode;
    logic trq_mode;

    assign pos_mode = (drive_status.control_mode == CTRL_POSITION);
    assign spd_mode = (drive_status.control_mode == CTRL_SPEED);
    // Unused mode encoding falls back to torque so one mode segment always shows
    assign trq_mode = !pos_mode && !spd_mode;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            indicators <= '0;
        end else begin
            indicators[IND_CTRL_POWER] <= drive_status.control_power_on; // [RULE11]
            indicators[IND_READY] <= drive_status.servo_ready; // [RULE12]
            indicators[IND_ENABLED] <= drive_status.servo_enabled; // [RULE13]
            if (pos_mode) begin
                indicators[IND_MATCH] <= drive_status.position_done_flag; // [RULE15]
                indicators[IND_CMD_A] <= drive_status.clear_input; // [RULE18]
                indicators[IND_CMD_B] <= drive_status.pulse_input_active; // [RULE18]
            end else begin
                indicators[IND_MATCH] <= spd_mode && drive_status.speed_match_flag; // [RULE14]
                indicators[IND_CMD_A] <= trq_mode && drive_status.torque_cmd_over; // [RULE17]
                indicators[IND_CMD_B] <= spd_mode && drive_status.speed_cmd_over; // [RULE17]
            end
            indicators[IND_MAIN_POWER] <= drive_status.main_power_on; // [RULE16]
            indicators[IND_ROTATION] <= drive_status.rotation_detect_flag; // [RULE19]
            indicators[IND_POS_MODE] <= pos_mode; // [RULE20]
            indicators[IND_SPD_MODE] <= spd_mode; // [RULE20]
            indicators[IND_TRQ_MODE] <= trq_mode; // [RULE20]
            indicators[IND_JOG] <= drive_status.jog_mode || drive_status.program_jog_mode; // [RULE21]
            indicators[IND_FULL_LOOP] <= drive_status.full_closed_loop; // [RULE22]
            indicators[IND_AUX_5V] <= drive_status.aux_connector_5v_on; // [RULE22]
        end
    end

endmodule

/* dv/panel_chk.sv */
// Port-level assertions for the panel key and status display block
`timescale 1ns/1ps
module panel_chk
    import panel_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic key_mode,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_shift,
    input wire drive_status_s drive_status,
    input wire logic [VALUE_W-1:0] stored_value,
    input wire display_s display,
    input wire logic [IND_W-1:0] indicators,
    input wire logic value_commit,
    input wire logic [VALUE_W-1:0] commit_value,
    input wire logic alarm_reset
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Status one edge back; live keeps the first edge after reset out
    drive_status_s ps;
    logic live;
    always_ff @(posedge ref_clk) begin
        ps <= drive_status;
        live <= !reset;
    end
    sequence done_shown;
        ##2 display.code == SHOW_DONE;
    endsequence
    chk_ctrl_power_seg: assert property (live |-> indicators[IND_CTRL_POWER] == ps.control_power_on)
        else $error("segment 1 off control power");
    chk_enabled_seg: assert property (live |-> indicators[IND_ENABLED] == ps.servo_enabled)
        else $error("segment 3 off servo enable");
    chk_match_seg: assert property (live |-> indicators[IND_MATCH] == (ps.control_mode == CTRL_POSITION ?
        ps.position_done_flag : ps.control_mode == CTRL_SPEED && ps.speed_match_flag))
        else $error("segment 4 wrong for mode");
    chk_cmd_segs: assert property (live |-> indicators[IND_CMD_B:IND_CMD_A] == (ps.control_mode == CTRL_POSITION ?
        {ps.pulse_input_active, ps.clear_input} : ps.control_mode == CTRL_SPEED ? {ps.speed_cmd_over, 1'b0} :
        {1'b0, ps.torque_cmd_over}))
        else $error("segments 6 and 7 wrong for mode");
    chk_mode_onehot: assert property (live |-> $onehot(indicators[IND_TRQ_MODE:IND_POS_MODE]))
        else $error("mode segments not one-hot");
    chk_jog_seg: assert property (live |-> indicators[IND_JOG] == (ps.jog_mode | ps.program_jog_mode))
        else $error("segment 12 off jog modes");
    chk_commit_done: assert property (value_commit |-> done_shown)
        else $error("commit without done code");
    chk_alarm_pulse: assert property (alarm_reset |-> drive_status.alarm_active && key_up && key_down ##1 !alarm_reset)
        else $error("alarm reset pulse without cause");
    chk_alarm_show: assert property (live && ps.alarm_active && $past(ps.alarm_active) && display.menu_fn == FN_STATUS
        |-> display.code == SHOW_ALARM)
        else $error("alarm code not shown");
endmodule

/* dv/operator_model.sv */
// Operator model: presses the four panel keys, bit order mode, up, down, shift
`timescale 1ns/1ps
module operator_model (
    output logic [3:0] keys,
    input wire logic ref_clk
);
    initial keys = 4'h0;
    // Long gap after release so release-acting keys settle before the next press
    task automatic press(input logic [3:0] mask, input int hold);
        @(posedge ref_clk);
        #1 keys = mask;
        repeat (hold) @(posedge ref_clk);
        #1 keys = 4'h0;
        repeat (24) @(posedge ref_clk);
        #1;
    endtask
endmodule

/* dv/testbench.sv */
// Self-checking testbench for the panel key and status display block
`timescale 1ns/1ps
module testbench;
    import panel_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] keys;
    drive_status_s st;
    logic [VALUE_W-1:0] stored;
    display_s display;
    logic [IND_W-1:0] indicators;
    logic value_commit;
    logic [VALUE_W-1:0] commit_value;
    logic alarm_reset;
    int mismatches = 0;
    int samples_checked = 0;
    int pulses = 0;
    int commits = 0;
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        pulses += (alarm_reset === 1'b1);
        commits += (value_commit === 1'b1);
    end
    operator_model op (.keys(keys), .ref_clk(ref_clk));
    panel_keys_status_display #(.DEBOUNCE_LEN(4), .COMBO_HOLD_LEN(20), .BLINK_LEN(8), .DONE_LEN(10)) dut (
        .ref_clk(ref_clk), .reset(reset), .key_mode(keys[0]), .key_up(keys[1]), .key_down(keys[2]),
        .key_shift(keys[3]), .drive_status(st), .stored_value(stored), .display(display),
        .indicators(indicators), .value_commit(value_commit), .commit_value(commit_value),
        .alarm_reset(alarm_reset));
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        samples_checked++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic set_ok;
        st = '0;
        {st.control_power_on, st.servo_ready, st.bus_voltage_ok} = 3'h7;
        {st.forward_overtravel_input, st.reverse_overtravel_input} = 2'h3;
        st.control_mode = CTRL_SPEED;
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_codes;
        logic [5:0] cases [7] = '{6'h0e, 6'h0f, 6'h0d, 6'h09, 6'h07, 6'h1f, 6'h3f};
        show_code_e want [7] = '{SHOW_READY, SHOW_RUN, SHOW_REV_INHIBIT, SHOW_FWD_INHIBIT,
                                 SHOW_NOT_READY, SHOW_NOT_READY, SHOW_ALARM};
        logic p;
        foreach (cases[i]) begin
            set_ok();
            st.alarm_number = 8'h42;
            {st.alarm_active, st.fault_present, st.bus_voltage_ok, st.forward_overtravel_input,
             st.reverse_overtravel_input, st.servo_enabled} = cases[i];
            cyc(3);
            check(display.code, want[i], "status code");
        end
        check({display.digits[7:0], display.blink_mask}, {8'h42, 5'h1f}, "alarm flash");
        p = display.lit_phase;
        cyc(8);
        check(display.lit_phase, !p, "blink phase");
        set_ok();
        op.press(4'h8, 10);
        check({display.code, display.blink_mask}, {SHOW_READY, 5'h00}, "shift in status");
    endtask
    task automatic t_indicators;
        logic [14:0] pats [3] = '{15'h7fff, 15'h2aaa, 15'h5555};
        logic [14:0] f;
        logic [IND_W-1:0] e;
        logic p;
        logic s;
        logic t;
        for (int m = 0; m < 3; m++) begin
            foreach (pats[i]) begin
                f = pats[i];
                {st.aux_connector_5v_on, st.full_closed_loop, st.program_jog_mode, st.jog_mode,
                 st.rotation_detect_flag, st.pulse_input_active, st.clear_input, st.speed_cmd_over,
                 st.torque_cmd_over, st.main_power_on, st.position_done_flag, st.speed_match_flag,
                 st.servo_enabled, st.servo_ready, st.control_power_on} = f;
                st.control_mode = ctrl_mode_e'(m);
                p = (m == 0);
                s = (m == 1);
                t = (m == 2);
                e = {f[14], f[13], f[12] | f[11], t, s, p, f[10], p ? f[9] : s & f[7],
                     p ? f[8] : t & f[6], f[5], p ? f[4] : s & f[3], f[2:0]};
                cyc(2);
                check(indicators, e, "indicators");
            end
        end
    endtask
    task automatic t_modes;
        panel_fn_e seq [4] = '{FN_AUX, FN_PARAM, FN_MONITOR, FN_STATUS};
        foreach (seq[i]) begin
            op.press(4'h1, 10);
            check(display.menu_fn, seq[i], "function step");
        end
    endtask
    task automatic t_edit;
        stored = 20'h00099;
        op.press(4'h1, 10);
        op.press(4'h1, 10);
        op.press(4'h8, 10);
        check({display.digits, display.blink_mask}, {20'h00099, 5'h01}, "edit opens");
        op.press(4'h2, 10);
        check(display.digits, 20'h00100, "up with carry");
        op.press(4'h2, 2);
        check(display.digits, 20'h00100, "short press lost");
        op.press(4'h8, 10);
        check(display.blink_mask, 5'h02, "digit moves left");
        op.press(4'h4, 10);
        check(display.digits, 20'h00090, "down with borrow");
        st.alarm_active = 1'b1;
        op.press(4'h6, 40);
        st.alarm_active = 1'b0;
        check({pulses[7:0], display.digits}, {8'h01, 20'h00090}, "combo");
        op.press(4'h1, 10);
        check({commits[7:0], commit_value}, {8'h01, 20'h00090}, "commit");
        check({display.code, display.menu_fn}, {SHOW_FUNCTION, FN_PARAM}, "after done");
        op.press(4'h1, 10);
        check(display.menu_fn, FN_MONITOR, "mode after commit");
    endtask
    initial begin
        st = '0;
        stored = '0;
        cyc(5);
        check({display.menu_fn, display.blink_mask, indicators}, {FN_STATUS, 5'h00, 14'h0}, "reset");
        reset = 1'b0;
        t_codes();
        t_indicators();
        set_ok();
        t_modes();
        t_edit();
        wrap_up();
    end
    initial begin
        #40000;
        mismatches++;
        wrap_up();
    end
endmodule
bind panel_keys_status_display panel_chk chk (.ref_clk, .reset, .key_mode, .key_up, .key_down, .key_shift,
    .drive_status, .stored_value, .display, .indicators, .value_commit, .commit_value, .alarm_reset);
